//--- fpet_assertions.sv
// Checker: wire rules between the core and the error glue
`timescale 1ns/1ps
module fpet_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Link wires
  input wire logic float_error_out_n,
  input wire logic ignore_numeric_error_n,
  input wire logic fp_error_irq_line,
  input wire logic io_wr,
  input wire logic [15:0] io_addr
);
  // ==========================================================
  // Shorthands
  wire f = float_error_out_n;
  wire g = ignore_numeric_error_n;
  wire q = fp_error_irq_line;
  wire hit = io_wr && io_addr == fpet_pkg::FP_ERR_CLR_PORT;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Properties
  irq_port_clear_a: assert property (hit && !$fell(f) |=> !q)
    else $error("irq not cleared");
  ign_port_set_a: assert property (hit && !$rose(f) |=> !g)
    else $error("ignore not set");
  ign_err_clear_a: assert property ($rose(f) |=> g)
    else $error("ignore not reset");
  irq_err_set_a: assert property ($fell(f) |=> q)
    else $error("irq not set");
  irq_hold_a: assert property (q && !hit |=> q)
    else $error("irq dropped");
  ign_hold_a: assert property (!g && !$rose(f) |=> !g)
    else $error("ignore dropped");
  ign_no_reset_a: assert property ($fell(f) && g && !hit |=> g)
    else $error("ignore set by error");
  irq_cause_a: assert property ($rose(q) |-> $past(f, 2) && !$past(f))
    else $error("irq without error");
endmodule // fpet_assertions

//--- fpet_core.sv
// Core end: fp error pin, ignore-error input and unavailable traps
// What this block does
// - Glue clears irq on port 0F0H access
// - Same access asserts ignore-error input
// - Ignore-error lets waiting ops run
// - Clear-errors op deasserts error pin
// - State save clears errors, deasserts pin
// - Restore with errors re-asserts pin
// - Pending error faults waiting op
// - Save ignore-error state across management mode
// - Hardware task switch sets task flag
// - Task flag faults fp ops, vector 7
// - Software sets flag; clear op clears
// - Emulation flag faults fp ops too
// - Emulation flag makes SIMD invalid opcode
// - Unavailable fault beats numeric error
`timescale 1ns/1ps
module fpet_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Link to the glue
  fpet_if.core lnk,
  // Instruction issue
  input wire logic op_valid,
  input wire fpet_pkg::fpet_op_t op_kind,
  input wire logic restore_has_err,
  input wire logic raise_err,
  // Control register zero access
  input wire logic hw_task_switch,
  input wire logic cr0_wr,
  input wire logic [31:0] cr0_wdata,
  output logic [31:0] cr0_rdata,
  // Exception report
  output logic op_done,
  output logic fault_valid,
  output logic [7:0] fault_vector
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] cr0;
    logic err_pend;
    logic float_error_out_n_n;
    logic done;
    logic fault;
    logic [7:0] vec;
  } fpet_core_st_t;

  fpet_core_st_t s_q, s_d;

  function automatic logic is_fp_op(input fpet_pkg::fpet_op_t k);
    is_fp_op = (k != fpet_pkg::FPET_OP_NONE) &&
               (k != fpet_pkg::FPET_OP_CLEAR_TS) &&
               (k != fpet_pkg::FPET_OP_SIMD_INT);
  endfunction

  logic ts, em, ign;
  assign ts = s_q.cr0[fpet_pkg::CR0_TS_BIT];
  assign em = s_q.cr0[fpet_pkg::CR0_EM_BIT];
  assign ign = ~lnk.ignore_numeric_error_n;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.fault = 1'b0;
    s_d.vec = fpet_pkg::VEC_NONE;
    // Software write first so a task switch in the same cycle still sets
    if (cr0_wr) begin
      s_d.cr0 = cr0_wdata;
    end
    if (hw_task_switch) begin
      s_d.cr0[fpet_pkg::CR0_TS_BIT] = 1'b1;
    end
    if (op_valid) begin
      if (op_kind == fpet_pkg::FPET_OP_CLEAR_TS) begin
        s_d.cr0[fpet_pkg::CR0_TS_BIT] = hw_task_switch;
        s_d.done = 1'b1;
      end else if (op_kind == fpet_pkg::FPET_OP_SIMD_INT) begin
        if (em) begin
          s_d.fault = 1'b1;
          s_d.vec = fpet_pkg::VEC_INVALID_OPCODE;
        end else if (ts) begin
          s_d.fault = 1'b1;
          s_d.vec = fpet_pkg::VEC_DEV_UNAVAIL;
        end else begin
          s_d.done = 1'b1;
        end
      end else if (is_fp_op(op_kind) && (ts || em)) begin
        // Checked before any numeric error
        s_d.fault = 1'b1;
        s_d.vec = fpet_pkg::VEC_DEV_UNAVAIL;
      end else begin
        case (op_kind)
          fpet_pkg::FPET_OP_WAITING: begin
            if (s_q.err_pend && !ign) begin
              s_d.fault = 1'b1;
              s_d.vec = fpet_pkg::VEC_FP_ERROR;
            end else begin
              s_d.done = 1'b1;
              if (raise_err) begin
                s_d.err_pend = 1'b1;
              end
            end
          end
          fpet_pkg::FPET_OP_NOWAIT: begin
            s_d.done = 1'b1;
          end
          fpet_pkg::FPET_OP_CLEAR_ERR: begin
            s_d.err_pend = 1'b0;
            s_d.done = 1'b1;
          end
          fpet_pkg::FPET_OP_SAVE: begin
            s_d.err_pend = 1'b0;
            s_d.done = 1'b1;
          end
          fpet_pkg::FPET_OP_RESTORE: begin
            s_d.err_pend = restore_has_err;
            s_d.done = 1'b1;
          end
          default: begin
            s_d.done = 1'b0;
          end
        endcase
      end
    end
    // Pin follows pending errors in the same cycle
    s_d.float_error_out_n_n = ~s_d.err_pend;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.cr0 <= fpet_pkg::CR0_RESET;
      s_q.err_pend <= 1'b0;
      s_q.float_error_out_n_n <= 1'b1;
      s_q.done <= 1'b0;
      s_q.fault <= 1'b0;
      s_q.vec <= fpet_pkg::VEC_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.float_error_out_n = s_q.float_error_out_n_n;
  assign cr0_rdata = s_q.cr0;
  assign op_done = s_q.done;
  assign fault_valid = s_q.fault;
  assign fault_vector = s_q.vec;
endmodule // fpet_core

//--- fpet_glue.sv
// Glue end: the two external flip-flops for fp error signalling
`timescale 1ns/1ps
module fpet_glue (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Link to the core and the io bus
  fpet_if.glue lnk,
  // Management mode save and restore of the ignore flip-flop
  input wire logic mgmt_save,
  input wire logic mgmt_restore,
  output logic mgmt_saved_ign
);
  // ==========================================================
  // State
  typedef struct packed {
    logic irq;
    logic ign;
    logic float_error_out_n_prev_n;
    logic saved;
  } fpet_glue_st_t;

  fpet_glue_st_t s_q, s_d;
  logic port_hit, float_error_out_n_fall, float_error_out_n_rise;

  assign port_hit = lnk.io_wr && (lnk.io_addr == fpet_pkg::FP_ERR_CLR_PORT);
  assign float_error_out_n_fall = s_q.float_error_out_n_prev_n && !lnk.float_error_out_n;
  assign float_error_out_n_rise = !s_q.float_error_out_n_prev_n && lnk.float_error_out_n;

  always_comb begin
    s_d = s_q;
    s_d.float_error_out_n_prev_n = lnk.float_error_out_n;
    // New error wins over a same-cycle port clear
    if (port_hit) begin
      s_d.irq = 1'b0;
    end
    if (float_error_out_n_fall) begin
      s_d.irq = 1'b1;
    end
    if (port_hit) begin
      s_d.ign = 1'b1;
    end
    if (float_error_out_n_rise) begin
      s_d.ign = 1'b0;
    end
    if (mgmt_save) begin
      s_d.saved = s_q.ign;
    end
    if (mgmt_restore) begin
      s_d.ign = s_q.saved;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q.irq <= 1'b0;
      s_q.ign <= 1'b0;
      s_q.float_error_out_n_prev_n <= 1'b1;
      s_q.saved <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.fp_error_irq_line = s_q.irq;
  assign lnk.ignore_numeric_error_n = ~s_q.ign;
  assign mgmt_saved_ign = s_q.saved;
endmodule // fpet_glue

//--- fpet_if.sv
// Interface: wires between the core and the external error glue
`timescale 1ns/1ps
interface fpet_if;
  logic float_error_out_n;
  logic ignore_numeric_error_n;
  logic fp_error_irq_line;
  logic io_wr;
  logic [15:0] io_addr;
  modport core (
    output float_error_out_n,
    input ignore_numeric_error_n
  );
  modport glue (
    input float_error_out_n,
    input io_wr,
    input io_addr,
    output ignore_numeric_error_n,
    output fp_error_irq_line
  );
  modport bus (
    output io_wr,
    output io_addr
  );
endinterface : fpet_if

//--- fpet_pkg.sv
// Package: shared constants and types for the fp error and trap block
package fpet_pkg;
  // ==========================================================
  // Control register zero fields
  localparam int unsigned CR0_EM_BIT = 2;
  localparam int unsigned CR0_TS_BIT = 3;
  localparam logic [31:0] CR0_RESET = 32'h0000_0000;
  // ==========================================================
  // Exception vectors
  localparam logic [7:0] VEC_NONE = 8'hFF;
  localparam logic [7:0] VEC_INVALID_OPCODE = 8'h06;
  localparam logic [7:0] VEC_DEV_UNAVAIL = 8'h07;
  localparam logic [7:0] VEC_FP_ERROR = 8'h10;
  // ==========================================================
  // Glue port decoded by the external flip-flops
  localparam logic [15:0] FP_ERR_CLR_PORT = 16'h00F0;
  // ==========================================================
  // Instruction classes presented to the core
  typedef enum logic [7:0] {
    FPET_OP_NONE = 8'h01,
    FPET_OP_WAITING = 8'h02,
    FPET_OP_NOWAIT = 8'h04,
    FPET_OP_CLEAR_ERR = 8'h08,
    FPET_OP_SAVE = 8'h10,
    FPET_OP_RESTORE = 8'h20,
    FPET_OP_SIMD_INT = 8'h40,
    FPET_OP_CLEAR_TS = 8'h80
  } fpet_op_t;
endpackage : fpet_pkg

//--- fpu_error_and_unavail_trap_bench.sv
// Testbench: core and glue joined, directed and random traffic
`timescale 1ns/1ps
module fpu_error_and_unavail_trap_bench;
  logic sys_clk = 1'b0, arst_n = 1'b0, opv = 1'b0, re = 1'b0, rh = 1'b0;
  logic hts = 1'b0, cw = 1'b0, ms = 1'b0, mr = 1'b0, sv, dn, fv;
  logic [31:0] wd = 32'h0, rd, r;
  logic [7:0] vec;
  fpet_pkg::fpet_op_t kd = fpet_pkg::FPET_OP_NONE;
  int n_fail = 0, checks = 0, seed = 11;
  bit ts, em, pend, ign, irq;
  fpet_if lnk ();
  fpet_core i_fpet_core (.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk),
    .op_valid(opv), .op_kind(kd), .restore_has_err(rh), .raise_err(re),
    .hw_task_switch(hts), .cr0_wr(cw), .cr0_wdata(wd), .cr0_rdata(rd),
    .op_done(dn), .fault_valid(fv), .fault_vector(vec));
  fpet_glue i_fpet_glue (.sys_clk(sys_clk), .arst_n(arst_n), .lnk(lnk),
    .mgmt_save(ms), .mgmt_restore(mr), .mgmt_saved_ign(sv));
  fpet_assertions i_fpet_assertions (.sys_clk(sys_clk), .arst_n(arst_n),
    .float_error_out_n(lnk.float_error_out_n), .io_wr(lnk.io_wr),
    .ignore_numeric_error_n(lnk.ignore_numeric_error_n),
    .fp_error_irq_line(lnk.fp_error_irq_line), .io_addr(lnk.io_addr));
  always #10 sys_clk = ~sys_clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] exp_vec(fpet_pkg::fpet_op_t k);
    if (k == fpet_pkg::FPET_OP_CLEAR_TS) return 8'hFF;
    if (k == fpet_pkg::FPET_OP_SIMD_INT) return em ? 8'h06 : ts ? 8'h07 : 8'hFF;
    if (ts || em) return 8'h07;
    return (k == fpet_pkg::FPET_OP_WAITING && pend && !ign) ? 8'h10 : 8'hFF;
  endfunction
  task automatic op(fpet_pkg::fpet_op_t k, bit x, bit h);
    logic [7:0] v;
    bit p0;
    v = exp_vec(k);
    p0 = pend;
    @(posedge sys_clk);
    opv <= 1'b1;
    kd <= k;
    {re, rh} <= {x, h};
    @(posedge sys_clk);
    opv <= 1'b0;
    #1;
    chk("answer", {v, v == 8'hFF, v != 8'hFF}, {vec, dn, fv});
    if (v == 8'hFF) begin
      if (k == fpet_pkg::FPET_OP_CLEAR_TS) ts = 0;
      if (k inside {fpet_pkg::FPET_OP_CLEAR_ERR, fpet_pkg::FPET_OP_SAVE})
        pend = 0;
      if (k == fpet_pkg::FPET_OP_RESTORE) pend = h;
      if (k == fpet_pkg::FPET_OP_WAITING && x) pend = 1;
    end
    chk("error pin", !pend, lnk.float_error_out_n);
    @(posedge sys_clk);
    #1;
    if (pend && !p0) irq = 1;
    if (!pend && p0) ign = 0;
    chk("glue", {irq, !ign}, {lnk.fp_error_irq_line,
      lnk.ignore_numeric_error_n});
  endtask
  task automatic port_wr();
    @(posedge sys_clk);
    {lnk.io_wr, lnk.io_addr} <= {1'b1, 16'h00F0};
    @(posedge sys_clk);
    lnk.io_wr <= 1'b0;
    #1;
    {irq, ign} = 2'h1;
    chk("port", 2'h0, {lnk.fp_error_irq_line,
      lnk.ignore_numeric_error_n});
  endtask
  task automatic cr0(bit h, logic [31:0] d);
    @(posedge sys_clk);
    {hts, cw, wd} <= {h, !h, d};
    @(posedge sys_clk);
    {hts, cw} <= 2'h0;
    if (h) ts = 1;
    else {ts, em} = d[3:2];
    @(posedge sys_clk);
    #1;
    chk("cr0", {28'h0, ts, em, 2'h0}, rd);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    lnk.io_wr = 1'b0;
    lnk.io_addr = 16'h0000;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("idle", 32'h7FE, {vec, lnk.float_error_out_n,
      lnk.ignore_numeric_error_n, lnk.fp_error_irq_line});
    arst_n <= 1'b1;
    op(fpet_pkg::FPET_OP_WAITING, 1, 0);
    op(fpet_pkg::FPET_OP_WAITING, 0, 0);
    port_wr();
    op(fpet_pkg::FPET_OP_WAITING, 0, 0);
    @(posedge sys_clk) ms <= 1'b1;
    @(posedge sys_clk) ms <= 1'b0;
    op(fpet_pkg::FPET_OP_SAVE, 0, 0);
    op(fpet_pkg::FPET_OP_RESTORE, 0, 1);
    op(fpet_pkg::FPET_OP_WAITING, 0, 0);
    @(posedge sys_clk) mr <= 1'b1;
    @(posedge sys_clk) mr <= 1'b0;
    #1;
    ign = 1;
    chk("saved", 2'h2, {sv, lnk.ignore_numeric_error_n});
    op(fpet_pkg::FPET_OP_CLEAR_ERR, 0, 0);
    port_wr();
    op(fpet_pkg::FPET_OP_WAITING, 1, 0);
    cr0(1, 0);
    op(fpet_pkg::FPET_OP_WAITING, 0, 0);
    op(fpet_pkg::FPET_OP_CLEAR_TS, 0, 0);
    cr0(0, 32'h8);
    op(fpet_pkg::FPET_OP_NOWAIT, 0, 0);
    cr0(0, 32'h4);
    op(fpet_pkg::FPET_OP_SAVE, 0, 0);
    op(fpet_pkg::FPET_OP_SIMD_INT, 0, 0);
    repeat (300) begin
      r = $random(seed);
      if (r[4:3] == 2'h0)
        cr0(r[5], {28'h0, r[7:6], 2'h0});
      else if (r[4:3] == 2'h1)
        port_wr();
      else
        op(fpet_pkg::fpet_op_t'(8'h02 << (r[2:0] % 7)), r[8], r[9]);
    end
    tally_and_finish();
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule // fpu_error_and_unavail_trap_bench
